// File: hdl/test_point_pkg.sv
package test_point_pkg;

  // Port geometry.
  localparam int unsigned TP_WIDTH      = 8;
  localparam int unsigned MODE_LSB      = 3;
  localparam int unsigned MODE_WIDTH    = 4;
  localparam int unsigned SCENARIO_LSB  = 0;
  localparam int unsigned SCEN_WIDTH    = 3;

  // Core clock rate and the power sequencing times derived from it.
  localparam int unsigned CLK_PERIOD_NS      = 50;
  localparam int unsigned POWER_UP_TIME_US   = 10;
  localparam int unsigned POWER_DOWN_TIME_US = 10;
  localparam int unsigned POWER_UP_CYCLES    =
    (POWER_UP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWER_DOWN_CYCLES  =
    (POWER_DOWN_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWR_CNT_WIDTH      = 16;

  // Strap scenarios on the low three captured bits.
  localparam logic [2:0] SCEN_QUIET     = 3'h0;
  localparam logic [2:0] SCEN_CLK_DEBUG = 3'h2;

  // Per-pin output source selection.
  typedef enum logic [2:0] {
    SRC_HIZ      = 3'b000,
    SRC_LOW      = 3'b001,
    SRC_HIGH     = 3'b010,
    SRC_CLK_FAST = 3'b011,
    SRC_CLK_VAR  = 3'b100,
    SRC_CLK_SLOW = 3'b101
  } tp_source_t;

  typedef logic [TP_WIDTH-1:0][2:0] tp_select_t;

  // Debug clocks supplied by the clock tree: 60 MHz, 0.7-22.5 MHz and 7.5 MHz.
  typedef struct packed {
    logic clk_fast;
    logic clk_var;
    logic clk_slow;
  } debug_clocks_t;

  // Captured strap configuration.
  typedef struct packed {
    logic [MODE_WIDTH-1:0] mode;
    logic [SCEN_WIDTH-1:0] scenario;
  } strap_cfg_t;

  // Projector power states.
  typedef enum logic [1:0] {
    PWR_OFF  = 2'b00,
    PWR_UP   = 2'b01,
    PWR_ON   = 2'b10,
    PWR_DOWN = 2'b11
  } pwr_state_t;

endpackage : test_point_pkg

// File: hdl/strap_capture.sv
`timescale 1ns/1ps
`default_nettype none

module strap_capture #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pins_in,
  output logic                  captured_valid,
  output logic [WIDTH-1:0]      captured
);

  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] cap_r;
  logic [WIDTH-1:0] cap_nxt;
  logic             valid_r;
  logic             valid_nxt;

  // Synchroniser runs through reset so the straps are settled at release.
  always_ff @(posedge clk) begin
    sync1_r <= pins_in;
    sync2_r <= sync1_r;
  end

  // The first edge after reset release takes the synchronised straps once.
  always_comb begin
    cap_nxt   = cap_r;
    valid_nxt = valid_r;
    if (!valid_r) begin
      cap_nxt   = sync2_r;
      valid_nxt = 1'b1;
    end
  end

  // Reset clears the capture so only a fresh release samples again.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_r   <= '0;
      valid_r <= 1'b0;
    end else begin
      cap_r   <= cap_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign captured_valid = valid_r;
  assign captured       = cap_r;

endmodule : strap_capture

`default_nettype wire

// File: hdl/test_point_strap_debug_port.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Test points are inputs during reset; after release those given a driving source become outputs.
// - Pin levels captured at reset release configure test mode until next reset.
// - Internal pulldowns make unstrapped pins capture as zero.
// - Captured scenario x000 leaves all eight test points high impedance.
// - Straps sampled only on reset rising edge; later changes ignored.
// - Captured bits 6:3 pick mode option, bits 2:0 pick output scenario.
// - Clock-debug scenario drives 60 MHz on point 0, 7.5 MHz on 7.
// - Clock-debug: variable clock on 2, points 3,5,6 high, 4 low, 1 unused.
// - Strap selections are defaults; software may reprogram them after reset.
// - Power request high makes the projector power up and project.
// - Power request low makes the projector power down to microwatts.
module test_point_strap_debug_port
  import test_point_pkg::*;
#(
  parameter int unsigned UP_CYCLES   = POWER_UP_CYCLES,
  parameter int unsigned DOWN_CYCLES = POWER_DOWN_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic [TP_WIDTH-1:0]    test_point_in,
  output logic      [TP_WIDTH-1:0]    test_point_out,
  output logic      [TP_WIDTH-1:0]    test_point_oe,
  input  wire debug_clocks_t          debug_clocks,
  input  wire logic                   select_write,
  input  wire tp_select_t             select_data,
  output tp_select_t                  select_current,
  output strap_cfg_t                  strap_cfg,
  output logic                        strap_valid,
  input  wire logic                   projector_power_request,
  output logic                        power_enable,
  output logic                        projecting
);

  logic                  cap_valid;
  logic [TP_WIDTH-1:0]   cap_value;

  tp_select_t            sel_r;
  tp_select_t            sel_nxt;
  logic                  loaded_r;
  logic                  loaded_nxt;
  strap_cfg_t            cfg_r;
  strap_cfg_t            cfg_nxt;

  logic [TP_WIDTH-1:0]   out_r;
  logic [TP_WIDTH-1:0]   out_nxt;
  logic [TP_WIDTH-1:0]   oe_r;
  logic [TP_WIDTH-1:0]   oe_nxt;

  pwr_state_t            pwr_r;
  pwr_state_t            pwr_nxt;
  logic [PWR_CNT_WIDTH-1:0] cnt_r;
  logic [PWR_CNT_WIDTH-1:0] cnt_nxt;
  logic                  pen_r;
  logic                  pen_nxt;
  logic                  proj_r;
  logic                  proj_nxt;

  localparam logic [PWR_CNT_WIDTH-1:0] UP_LOAD   = PWR_CNT_WIDTH'(UP_CYCLES - 1);
  localparam logic [PWR_CNT_WIDTH-1:0] DOWN_LOAD = PWR_CNT_WIDTH'(DOWN_CYCLES - 1);

  // Default source table for a captured scenario.
  function automatic tp_select_t default_select(input logic [SCEN_WIDTH-1:0] scen);
    tp_select_t s;
    s = {TP_WIDTH{SRC_HIZ}};
    if (scen == SCEN_CLK_DEBUG) begin
      s[0] = SRC_CLK_FAST;
      s[1] = SRC_HIZ;
      s[2] = SRC_CLK_VAR;
      s[3] = SRC_HIGH;
      s[4] = SRC_LOW;
      s[5] = SRC_HIGH;
      s[6] = SRC_HIGH;
      s[7] = SRC_CLK_SLOW;
    end
    return s;
  endfunction : default_select

  // Straps read the raw pin; the pad pulldown makes an open pin read zero.
  strap_capture #(
    .WIDTH          (TP_WIDTH)
  ) u_strap_capture (
    .clk            (clk),
    .reset_n        (reset_n),
    .pins_in        (test_point_in),
    .captured_valid (cap_valid),
    .captured       (cap_value)
  );

  // Selection state: strap defaults load once, software may then overwrite.
  always_comb begin
    sel_nxt    = sel_r;
    loaded_nxt = loaded_r;
    cfg_nxt    = cfg_r;
    if (cap_valid && !loaded_r) begin
      cfg_nxt.mode     = cap_value[MODE_LSB +: MODE_WIDTH];
      cfg_nxt.scenario = cap_value[SCENARIO_LSB +: SCEN_WIDTH];
      sel_nxt    = default_select(cap_value[SCENARIO_LSB +: SCEN_WIDTH]);
      loaded_nxt = 1'b1;
    end else if (loaded_r && select_write) begin
      sel_nxt = select_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_r    <= {TP_WIDTH{SRC_HIZ}};
      loaded_r <= 1'b0;
      cfg_r    <= '0;
    end else begin
      sel_r    <= sel_nxt;
      loaded_r <= loaded_nxt;
      cfg_r    <= cfg_nxt;
    end
  end

  // Pin drivers: enables stay low until the straps have been taken.
  always_comb begin
    out_nxt = '0;
    oe_nxt  = '0;
    for (int i = 0; i < TP_WIDTH; i++) begin
      case (tp_source_t'(sel_r[i]))
        SRC_HIZ: begin
          out_nxt[i] = 1'b0;
          oe_nxt[i]  = 1'b0;
        end
        SRC_LOW: begin
          out_nxt[i] = 1'b0;
          oe_nxt[i]  = loaded_r;
        end
        SRC_HIGH: begin
          out_nxt[i] = 1'b1;
          oe_nxt[i]  = loaded_r;
        end
        SRC_CLK_FAST: begin
          out_nxt[i] = debug_clocks.clk_fast;
          oe_nxt[i]  = loaded_r;
        end
        SRC_CLK_VAR: begin
          out_nxt[i] = debug_clocks.clk_var;
          oe_nxt[i]  = loaded_r;
        end
        SRC_CLK_SLOW: begin
          out_nxt[i] = debug_clocks.clk_slow;
          oe_nxt[i]  = loaded_r;
        end
        default: begin
          out_nxt[i] = 1'b0;
          oe_nxt[i]  = 1'b0;
        end
      endcase
    end
  end

  // Reset forces every test point to input.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_r <= '0;
      oe_r  <= '0;
    end else begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // Projector on/off sequencer with fixed power-up and power-down times.
  always_comb begin
    pwr_nxt  = pwr_r;
    cnt_nxt  = cnt_r;
    pen_nxt  = pen_r;
    proj_nxt = 1'b0;
    case (pwr_r)
      PWR_OFF: begin
        pen_nxt = 1'b0;
        if (projector_power_request) begin
          pwr_nxt = PWR_UP;
          cnt_nxt = UP_LOAD;
          pen_nxt = 1'b1;
        end
      end
      PWR_UP: begin
        if (!projector_power_request) begin
          pwr_nxt = PWR_DOWN;
          cnt_nxt = DOWN_LOAD;
        end else if (cnt_r == '0) begin
          pwr_nxt  = PWR_ON;
          proj_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      PWR_ON: begin
        proj_nxt = 1'b1;
        if (!projector_power_request) begin
          pwr_nxt  = PWR_DOWN;
          cnt_nxt  = DOWN_LOAD;
          proj_nxt = 1'b0;
        end
      end
      PWR_DOWN: begin
        if (cnt_r == '0) begin
          pwr_nxt = PWR_OFF;
          pen_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        pwr_nxt = PWR_OFF;
        pen_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_r  <= PWR_OFF;
      cnt_r  <= '0;
      pen_r  <= 1'b0;
      proj_r <= 1'b0;
    end else begin
      pwr_r  <= pwr_nxt;
      cnt_r  <= cnt_nxt;
      pen_r  <= pen_nxt;
      proj_r <= proj_nxt;
    end
  end

  // All outputs come from registers.
  assign test_point_out = out_r;
  assign test_point_oe  = oe_r;
  assign select_current = sel_r;
  assign strap_cfg      = cfg_r;
  assign strap_valid    = loaded_r;
  assign power_enable   = pen_r;
  assign projecting     = proj_r;

endmodule : test_point_strap_debug_port

`default_nettype wire

// File: verif/tp_props.sv
`timescale 1ns/1ps
`default_nettype none

module tp_props
  import test_point_pkg::*;
#(
  parameter int unsigned UP_CYCLES   = 4,
  parameter int unsigned DOWN_CYCLES = 4
) (
  input wire logic [TP_WIDTH-1:0] test_point_in,
  input wire logic [TP_WIDTH-1:0] test_point_out,
  input wire logic [TP_WIDTH-1:0] test_point_oe,
  input wire logic                clk,
  input wire logic                reset_n,
  input wire debug_clocks_t       debug_clocks,
  input wire logic                select_write,
  input wire tp_select_t          select_data,
  input wire tp_select_t          select_current,
  input wire strap_cfg_t          strap_cfg,
  input wire logic                strap_valid,
  input wire logic                projector_power_request,
  input wire logic                power_enable,
  input wire logic                projecting
);
  // All checks run on the core clock and rest while reset is held.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  localparam int UP_P1 = UP_CYCLES + 1;
  localparam int DN_P1 = DOWN_CYCLES + 1;

  strap_hold_a: assert property (strap_valid && $past(strap_valid) |-> $stable(strap_cfg))
    else $error("strap config moved after capture");
  strap_source_a: assert property ($rose(strap_valid) |-> strap_cfg == $past(test_point_in[6:0], 3))
    else $error("strap config differs from pin levels");
  quiet_hiz_a: assert property ($rose(strap_valid) && strap_cfg.scenario == SCEN_QUIET |=> test_point_oe == 8'h00)
    else $error("quiet scenario drives a pin");
  debug_default_a: assert property ($rose(strap_valid) && strap_cfg.scenario == SCEN_CLK_DEBUG |-> select_current == 24'ha91503)
    else $error("clock debug defaults wrong");
  select_load_a: assert property (strap_valid && select_write |=> select_current == $past(select_data))
    else $error("select write not loaded");
  low_pin_a: assert property ($past(select_current[4]) == SRC_LOW |-> test_point_oe[4] && !test_point_out[4])
    else $error("low source not driven low");
  fast_fwd_a: assert property ($past(select_current[0]) == SRC_CLK_FAST |-> test_point_oe[0] && test_point_out[0] == $past(debug_clocks.clk_fast))
    else $error("fast clock not forwarded");
  power_on_a: assert property ($rose(projector_power_request) && !power_enable |-> ##2 power_enable)
    else $error("power request not acted on");
  power_up_a: assert property ($rose(projecting) |-> $past(power_enable, UP_CYCLES) && !$past(power_enable, UP_P1))
    else $error("power up time wrong");
  stop_proj_a: assert property ($fell(projector_power_request) && projecting |-> ##2 !projecting)
    else $error("projection not stopped");
  power_down_a: assert property ($fell(power_enable) |-> !$past(projecting, DOWN_CYCLES) && $past(projecting, DN_P1))
    else $error("power down time wrong");

  cover property ($rose(projecting));
  cover property ($rose(strap_valid) && strap_cfg.scenario == SCEN_CLK_DEBUG);
  cover property (strap_valid && select_write);
endmodule : tp_props

bind test_point_strap_debug_port tp_props #(.UP_CYCLES(UP_CYCLES), .DOWN_CYCLES(DOWN_CYCLES)) props_u (
  .clk, .reset_n, .test_point_in, .test_point_out, .test_point_oe, .debug_clocks, .select_write,
  .select_data, .select_current, .strap_cfg, .strap_valid, .projector_power_request,
  .power_enable, .projecting);

`default_nettype wire

// File: verif/strap_board.sv
`timescale 1ns/1ps
`default_nettype none

module strap_board
  import test_point_pkg::*;
(
  input  wire logic [2:0] jumper,
  input  wire logic       clk,
  input  wire logic [7:0] lab_en,
  input  wire logic [7:0] lab_val,
  input  wire logic [7:0] test_point_out,
  input  wire logic [7:0] test_point_oe,
  output logic      [7:0] test_point_in,
  output debug_clocks_t   debug_clocks
);
  logic [2:0] cnt_r = 3'h0;

  // The chip wins where it drives, then the lab probe, then the jumpers; else the pulldown.
  assign test_point_in = (test_point_oe & test_point_out) |
    (~test_point_oe & ((lab_en & lab_val) | (~lab_en & {5'h00, jumper})));

  // Stand-in debug clocks at three rates, changed just after the core edge.
  always @(posedge clk) begin
    cnt_r <= #2 cnt_r + 3'h1;
  end
  assign debug_clocks = '{clk_fast: cnt_r[0], clk_var: cnt_r[1], clk_slow: cnt_r[2]};
endmodule : strap_board

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import test_point_pkg::*;
;
  logic          clk = 1'b0;
  logic          reset_n = 1'b0;
  logic          sel_wr = 1'b0;
  logic          pwr_req = 1'b0;
  logic [2:0]    jumper = 3'h0;
  logic [7:0]    lab_en = 8'h00;
  logic [7:0]    lab_val = 8'h00;
  tp_select_t    sel_data = 24'h000000;
  logic [7:0]    tp_in;
  logic [7:0]    tp_out;
  logic [7:0]    tp_oe;
  tp_select_t    sel_cur;
  strap_cfg_t    cfg;
  debug_clocks_t dbg_clk;
  logic          valid;
  logic          pwr_en;
  logic          proj;
  int            fails = 0;
  int            cmp_count = 0;

  always #25 clk = ~clk;

  test_point_strap_debug_port #(.UP_CYCLES(4), .DOWN_CYCLES(4)) dut_u (
    .clk(clk), .reset_n(reset_n), .test_point_in(tp_in), .test_point_out(tp_out),
    .test_point_oe(tp_oe), .debug_clocks(dbg_clk), .select_write(sel_wr),
    .select_data(sel_data), .select_current(sel_cur), .strap_cfg(cfg), .strap_valid(valid),
    .projector_power_request(pwr_req), .power_enable(pwr_en), .projecting(proj));

  strap_board board_u (.clk(clk), .jumper(jumper), .lab_en(lab_en), .lab_val(lab_val),
    .test_point_out(tp_out), .test_point_oe(tp_oe), .test_point_in(tp_in),
    .debug_clocks(dbg_clk));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Holds reset for five cycles with the given straps, then waits for the pins to settle.
  task automatic do_reset(input logic [2:0] jmp, input logic [7:0] en, input logic [7:0] val);
    jumper = jmp;
    lab_en = en;
    lab_val = val;
    reset_n = 1'b0;
    tick(5);
    chk("oe_in_reset", 24'h000000, {16'h0000, tp_oe});
    chk("valid_in_reset", 24'h000000, {23'h000000, valid});
    reset_n = 1'b1;
    tick(3);
  endtask : do_reset

  // Open straps give the quiet scenario, and later strap changes are ignored.
  task automatic t_quiet();
    do_reset(3'h0, 8'h00, 8'h00);
    chk("cfg_open", 24'h000000, {17'h00000, cfg});
    chk("oe_quiet", 24'h000000, {16'h0000, tp_oe});
    jumper = 3'h2;
    lab_en = 8'hff;
    lab_val = 8'hff;
    tick(4);
    chk("cfg_late", 24'h000000, {17'h00000, cfg});
    chk("oe_late", 24'h000000, {16'h0000, tp_oe});
    lab_en = 8'h00;
  endtask : t_quiet

  // Clock debug straps with the mode bits driven to 1010 on the probe.
  task automatic t_clk_dbg();
    do_reset(3'h2, 8'h78, 8'h50);
    lab_en = 8'h00;
    chk("cfg_debug", 24'h000052, {17'h00000, cfg});
    chk("sel_debug", 24'ha91503, sel_cur);
    chk("oe_debug", 24'h0000fd, {16'h0000, tp_oe});
    chk("levels_debug", 24'h00000d, {20'h00000, tp_out[6:3]});
  endtask : t_clk_dbg

  // Two writes back to back; the second one wins.
  task automatic t_write();
    sel_wr = 1'b1;
    sel_data = 24'h249249;
    tick(1);
    chk("sel_first", 24'h249249, sel_cur);
    sel_data = 24'h492492;
    tick(1);
    sel_wr = 1'b0;
    chk("sel_last", 24'h492492, sel_cur);
    chk("out_low", 24'h00ff00, {8'h00, tp_oe, tp_out});
    tick(1);
    chk("out_high", 24'h00ffff, {8'h00, tp_oe, tp_out});
  endtask : t_write

  // Power request up then down, with both sequencing counts set to four.
  task automatic t_power();
    pwr_req = 1'b1;
    tick(2);
    chk("pwr_up_en", 24'h000002, {22'h000000, pwr_en, proj});
    tick(2);
    chk("pwr_up_wait", 24'h000002, {22'h000000, pwr_en, proj});
    tick(1);
    chk("pwr_on", 24'h000003, {22'h000000, pwr_en, proj});
    pwr_req = 1'b0;
    tick(2);
    chk("pwr_stop", 24'h000002, {22'h000000, pwr_en, proj});
    tick(2);
    chk("pwr_dn_wait", 24'h000002, {22'h000000, pwr_en, proj});
    tick(1);
    chk("pwr_off", 24'h000000, {22'h000000, pwr_en, proj});
  endtask : t_power

  // The test sequence ends here.
  initial begin
    t_quiet();
    t_clk_dbg();
    t_write();
    t_power();
    test_done();
  end

  // A hang is cut short well after the sequence should have ended.
  initial begin
    repeat (400) @(posedge clk);
    fails++;
    test_done();
  end
endmodule : tb_top

`default_nettype wire
